// File: core/csb_alu.v
// Purpose: Combinational 8-bit adder, rotate and logic result with carries
// Assumes: Operation codes from csb_defines.vh
// Notes: Subtraction is done as an add of the two's complement
`timescale 1ns/1ps
`include "csb_defines.vh"
module csb_alu (
  // Operands
  input wire [3:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire carry_in,
  // Result
  output reg [7:0] result,
  output reg c_out,
  output reg dc_out
);
  reg [4:0] lo;
  reg [8:0] full;
  reg [7:0] bb;
  always @* begin
    lo = 5'h00;
    full = 9'h000;
    bb = b;
    result = b;
    c_out = carry_in;
    dc_out = 1'b0;
    case (op)
      `CSB_OP_ADD, `CSB_OP_SUB: begin
        // Two's complement of b as ~b + 1; carries then mean no-borrow
        bb = (op == `CSB_OP_SUB) ? ~b : b;
        lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, (op == `CSB_OP_SUB)};
        full = {1'b0, a} + {1'b0, bb} + {8'h00, (op == `CSB_OP_SUB)};
        result = full[7:0];
        dc_out = lo[4];
        c_out = full[8];
      end
      `CSB_OP_RLF: begin
        result = {b[6:0], carry_in};
        c_out = b[7];
      end
      `CSB_OP_RRF: begin
        result = {carry_in, b[7:1]};
        c_out = b[0];
      end
      `CSB_OP_FILE_ZEROING_INSTRUCTION: result = 8'h00;
      default: result = b;
    endcase
  end
endmodule // csb_alu

// File: core/csb_bank_decode.v
// Purpose: Splits a data address into bank and offset and classifies it
// Assumes: 12-bit banked address, 16-bit linear pointer address
// Notes: Purely combinational
`timescale 1ns/1ps
`include "csb_defines.vh"
module csb_bank_decode (
  // Banked address
  input wire [11:0] addr,
  // Linear pointer address
  input wire [15:0] lin_addr,
  // Decode
  output wire [4:0] bank,
  output wire [6:0] ofs,
  output reg [2:0] region,
  output reg lin_hit,
  output reg [11:0] lin_phys
);
  reg [15:0] lin_off;
  reg [15:0] lin_bank;
  reg [15:0] lin_rem;
  assign bank = addr[11:7];
  assign ofs = addr[6:0];
  always @* begin
    lin_off = 16'h0000;
    lin_bank = 16'h0000;
    lin_rem = 16'h0000;
    if (ofs <= `CSB_CORE_LAST)
      region = `CSB_REGION_CORE;
    else if (ofs <= `CSB_PERIPH_LAST)
      region = `CSB_REGION_PERIPH;
    else if (ofs <= `CSB_GRAM_LAST)
      region = `CSB_REGION_GRAM;
    else
      region = `CSB_REGION_COMMON;
    // Linear window stitches the general RAM of banks 0 to 30 end to end
    lin_hit = (lin_addr >= `CSB_LIN_BASE) && (lin_addr <= `CSB_LIN_LAST);
    lin_off = lin_addr - `CSB_LIN_BASE;
    lin_bank = lin_off / {9'h000, `CSB_GRAM_PER_BANK};
    lin_rem = lin_off % {9'h000, `CSB_GRAM_PER_BANK};
    lin_phys = {lin_bank[4:0], lin_rem[6:0] + `CSB_GRAM_FIRST};
  end
endmodule // csb_bank_decode

// File: core/csb_defines.vh
// Purpose: Constants for the CPU flag register and bank decode
// Assumes: 12-bit data address, 128-byte banks
// Notes: Included by every design file
`ifndef CSB_DEFINES_VH
`define CSB_DEFINES_VH
`define CSB_BIT_C 0
`define CSB_BIT_DC 1
`define CSB_BIT_Z 2
`define CSB_BIT_PD 3
`define CSB_BIT_TO 4
`define CSB_UNIMP_HI 7
`define CSB_UNIMP_LO 5
`define CSB_UNIMP_BITS 3'h0
`define CSB_FLAGS_RST 8'h18
`define CSB_ADDR_W 12
`define CSB_BANK_W 5
`define CSB_OFS_W 7
`define CSB_FLAGS_OFS 7'h03
`define CSB_CORE_LAST 7'h0b
`define CSB_PERIPH_FIRST 7'h0c
`define CSB_PERIPH_LAST 7'h1f
`define CSB_GRAM_FIRST 7'h20
`define CSB_GRAM_LAST 7'h6f
`define CSB_COMMON_FIRST 7'h70
`define CSB_GRAM_PER_BANK 7'h50
`define CSB_LIN_BASE 16'h2000
`define CSB_LIN_LAST 16'h29af
`define CSB_OP_NONE 4'h0
`define CSB_OP_ADD 4'h1
`define CSB_OP_SUB 4'h2
`define CSB_OP_LOGIC 4'h3
`define CSB_OP_RLF 4'h4
`define CSB_OP_RRF 4'h5
`define CSB_OP_FILE_ZEROING_INSTRUCTION 4'h6
`define CSB_OP_MOVE 4'h7
`define CSB_OP_ZONLY 4'h8
`define CSB_REGION_CORE 3'h0
`define CSB_REGION_PERIPH 3'h1
`define CSB_REGION_GRAM 3'h2
`define CSB_REGION_COMMON 3'h3
`define CSB_REGION_NONE 3'h4
`endif

// File: core/csb_flags.v
// Overview of operation
// - Flag register accepts writes like a file register, except from flag-affecting instructions.
// - Flag-affecting instruction targeting it: only the flags that op affects update from result; Z, DC, C are not written.
// - Time-out and power-down bits never change by instruction write.
// - File-zeroing on it clears upper bits, sets Z, keeps others.
// - Bits 7 to 5 read as zero always.
// - Time-out bit set by power-up, kick or sleep; cleared by expiry.
// - Power-down bit set by power-up or kick; cleared by sleep.
// - Zero flag is one exactly when the result is zero.
// - Add/subtract: nibble carry is carry out of bit 3.
// - Add/subtract: carry flag is carry out of bit 7.
// - Subtraction adds two's complement of second operand.
// - In subtraction both carries mean no borrow.
// - Rotates load carry with the bit shifted out.
// - Power-on resets: status bits one, flags zero; others by cause.
// - Offsets after core registers, 20 bytes, are peripheral registers.
// - Up to 80 bytes general RAM per bank after peripherals.
// - 16-byte common RAM at same offsets in every bank.
// - General RAM reachable linearly through indirect pointers.
// - Upper five address bits select bank, lower seven the offset.
//
// Purpose: CPU flag and reset-cause register with bank address decode
// Assumes: One instruction completes per SYS_CLK when INSTR_VALID is high
// Notes: Event inputs come from same-clock core logic, not pins
//   OTHER_RESET cancels the instruction that shares its cycle
//   Decode outputs are registered and describe DEST_ADDR and LIN_ADDR of the previous cycle
`timescale 1ns/1ps
`include "csb_defines.vh"
module csb_flags (
  // Clock and reset
  input wire SYS_CLK,
  input wire NRST,
  // Instruction execute
  input wire INSTR_VALID,
  input wire [3:0] INSTR_OP,
  input wire [7:0] OPERAND_A,
  input wire [7:0] OPERAND_B,
  input wire DEST_WRITE,
  input wire [11:0] DEST_ADDR,
  // Reset-cause and power events
  input wire WATCHDOG_KICK,
  input wire SLEEP_EXEC,
  input wire WATCHDOG_EXPIRY,
  input wire OTHER_RESET,
  input wire OTHER_RESET_WDT,
  // Linear pointer address
  input wire [15:0] LIN_ADDR,
  // Results
  output reg [7:0] FLAGS,
  output reg [7:0] RESULT,
  output reg RESULT_WE,
  output reg [11:0] RESULT_ADDR,
  output reg [2:0] REGION,
  output reg LIN_HIT,
  output reg [11:0] LIN_PHYS
);
  reg carry_r;
  reg nibble_carry_r;
  reg zero_r;
  reg watchdog_expiry_flag_r;
  reg powerdown_flag_r;
  reg carry_nxt;
  reg nibble_carry_nxt;
  reg zero_nxt;
  reg watchdog_expiry_flag_nxt;
  reg powerdown_flag_nxt;
  reg hit_flags;
  reg sets_z;
  reg sets_c;
  reg sets_dc;
  reg flag_op;
  reg data_wr_flags;
  reg run;
  reg result_we_nxt;
  wire [7:0] flags_nxt;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire [4:0] dec_bank;
  wire [6:0] dec_ofs;
  wire [2:0] dec_region;
  wire dec_lin_hit;
  wire [11:0] dec_lin_phys;

  // ------------------------------------------------------------
  // Datapath and decode
  // ------------------------------------------------------------
  csb_alu u_alu (
    .op(INSTR_OP),
    .a(OPERAND_A),
    .b(OPERAND_B),
    .carry_in(carry_r),
    .result(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc)
  );

  csb_bank_decode u_dec (
    .addr(DEST_ADDR),
    .lin_addr(LIN_ADDR),
    .bank(dec_bank),
    .ofs(dec_ofs),
    .region(dec_region),
    .lin_hit(dec_lin_hit),
    .lin_phys(dec_lin_phys)
  );

  // ------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------
  // Op classes follow which flags each instruction affects
  always @* begin
    hit_flags = INSTR_VALID && DEST_WRITE && (dec_ofs == `CSB_FLAGS_OFS);
    sets_z = (INSTR_OP == `CSB_OP_ADD) ||
             (INSTR_OP == `CSB_OP_SUB) ||
             (INSTR_OP == `CSB_OP_LOGIC) ||
             (INSTR_OP == `CSB_OP_FILE_ZEROING_INSTRUCTION) ||
             (INSTR_OP == `CSB_OP_ZONLY);
    sets_dc = (INSTR_OP == `CSB_OP_ADD) || (INSTR_OP == `CSB_OP_SUB);
    sets_c = sets_dc ||
             (INSTR_OP == `CSB_OP_RLF) || (INSTR_OP == `CSB_OP_RRF);
    // A non-power reset cancels the instruction of its cycle
    run = INSTR_VALID && !OTHER_RESET;
    flag_op = run && (sets_z || sets_dc || sets_c);
  end

  // ------------------------------------------------------------
  // Write enables
  // ------------------------------------------------------------
  always @* begin
    // One flag-affecting op locks all three bits, not only its own
    data_wr_flags = hit_flags && !OTHER_RESET && !flag_op;
    // The status target never reaches the RAM side
    result_we_nxt = run && DEST_WRITE && !hit_flags;
  end

  // ------------------------------------------------------------
  // Carry flag
  // ------------------------------------------------------------
  // Rotates shift through this bit as a ninth bit
  always @* begin
    carry_nxt = carry_r;
    if (run && sets_c) begin
      // Carry out doubles as the inverted borrow
      carry_nxt = alu_c;
    end else if (data_wr_flags) begin
      carry_nxt = alu_res[`CSB_BIT_C];
    end
  end

  // ------------------------------------------------------------
  // Nibble carry flag
  // ------------------------------------------------------------
  // Of the flag-affecting ops, only add and subtract touch this bit
  always @* begin
    nibble_carry_nxt = nibble_carry_r;
    if (run && sets_dc) begin
      nibble_carry_nxt = alu_dc;
    end else if (data_wr_flags) begin
      nibble_carry_nxt = alu_res[`CSB_BIT_DC];
    end
  end

  // ------------------------------------------------------------
  // Zero flag
  // ------------------------------------------------------------
  // A cancelled instruction leaves the flag alone
  always @* begin
    zero_nxt = zero_r;
    if (run && sets_z) begin
      zero_nxt = (alu_res == 8'h00);
    end else if (data_wr_flags) begin
      zero_nxt = alu_res[`CSB_BIT_Z];
    end
  end

  // ------------------------------------------------------------
  // Time-out flag
  // ------------------------------------------------------------
  // Instruction data never reaches this bit
  always @* begin
    watchdog_expiry_flag_nxt = watchdog_expiry_flag_r;
    if (OTHER_RESET) begin
      watchdog_expiry_flag_nxt = ~OTHER_RESET_WDT;
    end else if (WATCHDOG_EXPIRY) begin
      // Expiry beats kick and sleep so a time-out is never hidden
      watchdog_expiry_flag_nxt = 1'b0;
    end else if (WATCHDOG_KICK || SLEEP_EXEC) begin
      watchdog_expiry_flag_nxt = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Power-down flag
  // ------------------------------------------------------------
  // Instruction data never reaches this bit
  always @* begin
    powerdown_flag_nxt = powerdown_flag_r;
    if (OTHER_RESET) begin
      powerdown_flag_nxt = powerdown_flag_r;
    end else if (SLEEP_EXEC) begin
      // Sleep beats a kick in the same cycle
      powerdown_flag_nxt = 1'b0;
    end else if (WATCHDOG_KICK) begin
      powerdown_flag_nxt = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Flag image
  // ------------------------------------------------------------
  // Unimplemented bits are tied off so they always read zero
  assign flags_nxt[`CSB_UNIMP_HI:`CSB_UNIMP_LO] = `CSB_UNIMP_BITS;
  assign flags_nxt[`CSB_BIT_TO] = watchdog_expiry_flag_nxt;
  assign flags_nxt[`CSB_BIT_PD] = powerdown_flag_nxt;
  assign flags_nxt[`CSB_BIT_Z] = zero_nxt;
  assign flags_nxt[`CSB_BIT_DC] = nibble_carry_nxt;
  assign flags_nxt[`CSB_BIT_C] = carry_nxt;

  // ------------------------------------------------------------
  // Arithmetic flag registers
  // ------------------------------------------------------------
  // Power-on values: cause bits set, arithmetic flags clear
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      carry_r <= 1'b0;
    end else begin
      carry_r <= carry_nxt;
    end
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      nibble_carry_r <= 1'b0;
    end else begin
      nibble_carry_r <= nibble_carry_nxt;
    end
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      zero_r <= 1'b0;
    end else begin
      zero_r <= zero_nxt;
    end
  end

  // ------------------------------------------------------------
  // Reset-cause registers
  // ------------------------------------------------------------
  // Only a power-on reset sets these directly; others go through the cause logic
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      watchdog_expiry_flag_r <= 1'b1;
    end else begin
      watchdog_expiry_flag_r <= watchdog_expiry_flag_nxt;
    end
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      powerdown_flag_r <= 1'b1;
    end else begin
      powerdown_flag_r <= powerdown_flag_nxt;
    end
  end

  // ------------------------------------------------------------
  // Flag output
  // ------------------------------------------------------------
  // Shows the flags as they stand after this edge
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      FLAGS <= `CSB_FLAGS_RST;
    end else begin
      FLAGS <= flags_nxt;
    end
  end

  // ------------------------------------------------------------
  // Write-back outputs
  // ------------------------------------------------------------
  // Registered one cycle after execute, alongside the flags
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      RESULT <= 8'h00;
    end else begin
      RESULT <= alu_res;
    end
  end

  // A write to the flag register itself stays inside this block
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      RESULT_WE <= 1'b0;
    end else begin
      RESULT_WE <= result_we_nxt;
    end
  end

  // Bank in the upper five bits, offset in the lower seven
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      RESULT_ADDR <= 12'h000;
    end else begin
      RESULT_ADDR <= {dec_bank, dec_ofs};
    end
  end

  // ------------------------------------------------------------
  // Bank decode outputs
  // ------------------------------------------------------------
  // Reads as none during reset so no region is claimed early
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      REGION <= `CSB_REGION_NONE;
    end else begin
      REGION <= dec_region;
    end
  end

  // ------------------------------------------------------------
  // Linear window outputs
  // ------------------------------------------------------------
  // The physical address means something only while LIN_HIT is high
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      LIN_HIT <= 1'b0;
    end else begin
      LIN_HIT <= dec_lin_hit;
    end
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      LIN_PHYS <= 12'h000;
    end else begin
      LIN_PHYS <= dec_lin_phys;
    end
  end
endmodule // csb_flags

// File: tb/csb_flags_chk.sv
// Purpose: Port-level checks of the flag and reset-cause register
// Assumes: Flags settle one edge after their cause
// Notes: Bound to the top module, sees its ports only
`timescale 1ns/1ps
module csb_flags_chk (
  // Clock and reset
  input logic SYS_CLK,
  input logic NRST,
  // Instruction
  input logic INSTR_VALID,
  input logic [3:0] INSTR_OP,
  input logic [7:0] OPERAND_A,
  input logic [7:0] OPERAND_B,
  input logic DEST_WRITE,
  input logic [11:0] DEST_ADDR,
  // Events
  input logic WATCHDOG_KICK,
  input logic SLEEP_EXEC,
  input logic WATCHDOG_EXPIRY,
  input logic OTHER_RESET,
  input logic OTHER_RESET_WDT,
  // Outputs watched
  input logic [7:0] FLAGS,
  input logic RESULT_WE
);
  wire [8:0] add_sum = {1'b0, OPERAND_A} + {1'b0, OPERAND_B};
  wire [8:0] sub_sum = {1'b0, OPERAND_A} + {1'b0, ~OPERAND_B} + 9'h001;
  wire add_c = add_sum[8];
  wire sub_c = sub_sum[8];
  wire run = INSTR_VALID && !OTHER_RESET;
  wire no_ev = !WATCHDOG_KICK && !SLEEP_EXEC && !WATCHDOG_EXPIRY && !OTHER_RESET;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  AST_UPPER_ZERO: assert property (FLAGS[7:5] == 3'h0)
    else $error("flag bits 7..5 not zero");
  AST_STATUS_NO_WE: assert property (INSTR_VALID && DEST_WRITE &&
    DEST_ADDR[6:0] == 7'h03 |=> !RESULT_WE) else $error("flag target raised write");
  AST_KICK: assert property (WATCHDOG_KICK && !SLEEP_EXEC && !WATCHDOG_EXPIRY &&
    !OTHER_RESET |=> FLAGS[4:3] == 2'h3) else $error("kick did not set bits");
  AST_SLEEP: assert property (SLEEP_EXEC && !WATCHDOG_EXPIRY && !OTHER_RESET
    |=> FLAGS[4:3] == 2'h2) else $error("sleep bits wrong");
  AST_EXPIRY: assert property (WATCHDOG_EXPIRY && !OTHER_RESET |=> !FLAGS[4])
    else $error("expiry left time-out bit set");
  AST_CAUSE_HOLD: assert property (no_ev |=> $stable(FLAGS[4:3]))
    else $error("cause bits changed without event");
  AST_ADD_CARRY: assert property (run && INSTR_OP == 4'h1 |=> FLAGS[0] == $past(add_c))
    else $error("add carry wrong");
  AST_SUB_BORROW: assert property (run && INSTR_OP == 4'h2 |=> FLAGS[0] == $past(sub_c))
    else $error("subtract borrow wrong");
  AST_CLEAR_ZERO: assert property (run && INSTR_OP == 4'h6 |=> FLAGS[2] &&
    $stable(FLAGS[1:0])) else $error("clear did not set zero");
  AST_OTHER_CAUSE: assert property (OTHER_RESET |=> FLAGS[4] == !$past(OTHER_RESET_WDT)
    && !RESULT_WE && $stable(FLAGS[3:0])) else $error("other reset flags wrong");
endmodule // csb_flags_chk
bind csb_flags csb_flags_chk chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .INSTR_VALID(INSTR_VALID),
  .INSTR_OP(INSTR_OP), .OPERAND_A(OPERAND_A), .OPERAND_B(OPERAND_B), .DEST_WRITE(DEST_WRITE),
  .DEST_ADDR(DEST_ADDR), .WATCHDOG_KICK(WATCHDOG_KICK), .SLEEP_EXEC(SLEEP_EXEC),
  .WATCHDOG_EXPIRY(WATCHDOG_EXPIRY), .OTHER_RESET(OTHER_RESET),
  .OTHER_RESET_WDT(OTHER_RESET_WDT), .FLAGS(FLAGS), .RESULT_WE(RESULT_WE));

// File: tb/csb_flags_tb_top.sv
// Purpose: Self-checking bench for the flag register block
// Assumes: Results show one edge after the instruction
// Notes: Driver queues notes, monitor pops one per edge
`timescale 1ns/1ps
module csb_flags_tb_top;
  typedef struct {logic [7:0] f, r; logic w, c, h; logic [2:0] g; logic [11:0] p, a;} csb_note_t;
  logic SYS_CLK = 1'b0;
  logic NRST = 1'b0;
  logic INSTR_VALID = 1'b0;
  logic DEST_WRITE = 1'b0;
  logic WATCHDOG_KICK = 1'b0;
  logic SLEEP_EXEC = 1'b0;
  logic WATCHDOG_EXPIRY = 1'b0;
  logic OTHER_RESET = 1'b0;
  logic OTHER_RESET_WDT = 1'b0;
  logic [3:0] INSTR_OP = 4'h0;
  logic [7:0] OPERAND_A = 8'h00;
  logic [7:0] OPERAND_B = 8'h00;
  logic [11:0] DEST_ADDR = 12'h000;
  logic [15:0] LIN_ADDR = 16'h0000;
  wire [7:0] FLAGS;
  wire [7:0] RESULT;
  wire [11:0] RESULT_ADDR;
  wire [11:0] LIN_PHYS;
  wire [2:0] REGION;
  wire RESULT_WE;
  wire LIN_HIT;
  logic [7:0] m = 8'h18;
  logic [31:0] rv;
  logic [31:0] rw;
  logic [4:0] evs [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h01, 5'h08, 5'h18};
  int failures = 0;
  int n_compared = 0;
  int seed = 98944;
  csb_note_t q[$];
  csb_note_t nt;
  csb_flags uut (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .INSTR_VALID(INSTR_VALID), .INSTR_OP(INSTR_OP),
    .OPERAND_A(OPERAND_A), .OPERAND_B(OPERAND_B), .DEST_WRITE(DEST_WRITE),
    .DEST_ADDR(DEST_ADDR), .WATCHDOG_KICK(WATCHDOG_KICK), .SLEEP_EXEC(SLEEP_EXEC),
    .WATCHDOG_EXPIRY(WATCHDOG_EXPIRY), .OTHER_RESET(OTHER_RESET),
    .OTHER_RESET_WDT(OTHER_RESET_WDT), .LIN_ADDR(LIN_ADDR), .FLAGS(FLAGS), .RESULT(RESULT),
    .RESULT_WE(RESULT_WE), .RESULT_ADDR(RESULT_ADDR), .REGION(REGION), .LIN_HIT(LIN_HIT),
    .LIN_PHYS(LIN_PHYS)
  );
  always #12.5 SYS_CLK = ~SYS_CLK;
  task cmp_flags(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t flags got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_data(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t data got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Extra edge first, so the last queued note is compared before reset lands
  task do_reset;
    @(posedge SYS_CLK);
    #1 NRST = 1'b0;
    repeat (4) @(posedge SYS_CLK);
    cmp_flags(FLAGS, 8'h18);
    cmp_data({9'h000, REGION}, 12'h004);
    #1 NRST = 1'b1;
    m = 8'h18;
  endtask
  // Op 0 means an idle cycle; events still apply
  task automatic issue(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b,
      input logic [11:0] ad, input logic [4:0] ev, input logic [15:0] la);
    logic [8:0] s;
    logic [4:0] hs;
    logic [7:0] r;
    logic [7:0] bb;
    logic [11:0] lo;
    logic st;
    csb_note_t n;
    INSTR_VALID = op != 4'h0;
    DEST_WRITE = op != 4'h0;
    INSTR_OP = op;
    OPERAND_A = a;
    OPERAND_B = b;
    DEST_ADDR = ad;
    LIN_ADDR = la;
    {OTHER_RESET_WDT, OTHER_RESET, WATCHDOG_EXPIRY, SLEEP_EXEC, WATCHDOG_KICK} = ev;
    st = ad[6:0] == 7'h03;
    bb = op == 4'h2 ? ~b : b;
    s = a + bb + (op == 4'h2);
    hs = a[3:0] + bb[3:0] + (op == 4'h2);
    r = op inside {4'h1, 4'h2} ? s[7:0] : op == 4'h4 ? {b[6:0], m[0]} :
      op == 4'h5 ? {m[0], b[7:1]} : op == 4'h6 ? 8'h00 : b;
    n.f = m;
    if (op inside {4'h1, 4'h2}) n.f[1:0] = {hs[4], s[8]};
    if (op inside {4'h4, 4'h5}) n.f[0] = op == 4'h4 ? b[7] : b[0];
    if (op inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h8}) n.f[2] = r == 8'h00;
    if (st && op == 4'h7) n.f[2:0] = r[2:0];
    if (ev[0]) n.f[4:3] = 2'h3;
    if (ev[1]) n.f[4:3] = 2'h2;
    if (ev[2]) n.f[4] = 1'b0;
    if (ev[3]) n.f = {3'h0, ~ev[4], m[3:0]};
    n.w = op != 4'h0 && !st && !ev[3];
    n.c = op != 4'h0 && !ev[3];
    n.r = r;
    n.g = ad[6:0] < 7'h0c ? 3'h0 : ad[6:0] < 7'h20 ? 3'h1 : ad[6:0] < 7'h70 ? 3'h2 : 3'h3;
    n.h = la >= 16'h2000 && la <= 16'h29af;
    n.a = ad;
    lo = la[11:0];
    n.p = (lo / 12'h050) * 12'h080 + 12'h020 + lo % 12'h050;
    m = n.f;
    @(posedge SYS_CLK);
    q.push_back(n);
    #1;
  endtask
  initial begin
    forever begin
      @(posedge SYS_CLK);
      #2;
      if (q.size() > 0) begin
        nt = q.pop_front();
        cmp_flags(FLAGS, nt.f);
        cmp_data({11'h000, RESULT_WE}, {11'h000, nt.w});
        if (nt.w) cmp_data({4'h0, RESULT}, {4'h0, nt.r});
        if (nt.c) cmp_data({9'h000, REGION}, {9'h000, nt.g});
        if (nt.c) cmp_data(RESULT_ADDR, nt.a);
        cmp_data({11'h000, LIN_HIT}, {11'h000, nt.h});
        if (nt.h) cmp_data(LIN_PHYS, nt.p);
      end
    end
  end
  // 120 cycles are issued, 115 of them instructions; this allows ample slack
  initial begin
    #200000;
    failures++;
    stop_test;
  end
  initial begin
    do_reset;
    issue(4'h1, 8'h0f, 8'h01, 12'h020, 5'h00, 16'h2000);
    issue(4'h1, 8'hff, 8'h01, 12'h0a0, 5'h00, 16'h29af);
    issue(4'h2, 8'h05, 8'h05, 12'h170, 5'h00, 16'h29b0);
    issue(4'h2, 8'h00, 8'h01, 12'h10c, 5'h00, 16'h1fff);
    issue(4'h1, 8'h80, 8'h80, 12'h003, 5'h00, 16'h204f);
    issue(4'h7, 8'h00, 8'hfa, 12'h183, 5'h00, 16'h2050);
    issue(4'h6, 8'h00, 8'h00, 12'hf83, 5'h00, 16'h209f);
    issue(4'h4, 8'h00, 8'h80, 12'h06f, 5'h00, 16'h20a0);
    issue(4'h5, 8'h00, 8'h01, 12'h07f, 5'h00, 16'h2123);
    issue(4'h3, 8'h00, 8'h00, 12'h01f, 5'h00, 16'h0000);
    issue(4'h8, 8'h00, 8'h01, 12'h00b, 5'h00, 16'h2345);
    for (int i = 0; i < 8; i++) issue({3'h0, i[0]}, 8'h12, 8'h34, 12'h030, evs[i], 16'h2100);
    for (int i = 0; i < 100; i++) begin
      rv = $random(seed);
      rw = $random(seed);
      // Status target only with ops whose flag outcome is fully defined
      if (rv[9:3] == 7'h03 && !({1'b0, rv[2:0]} inside {4'h0, 4'h1, 4'h5, 4'h6})) rv[3] = 1'b0;
      issue({1'b0, rv[2:0]} + 4'h1, rw[7:0], rw[15:8], rv[14:3], 5'h00,
        16'h1f80 + {4'h0, rv[26:15]});
      if (i == 50) do_reset;
    end
    issue(4'h0, 8'h00, 8'h00, 12'h000, 5'h00, 16'h0000);
    @(posedge SYS_CLK);
    #3;
    stop_test;
  end
endmodule // csb_flags_tb_top
